// File: core/irq_bank_consts.vh
`ifndef IRQ_BANK_CONSTS_VH
`define IRQ_BANK_CONSTS_VH

// ----------------------------------------
// Register indices on the plain port
// ----------------------------------------
`define ADDR_W          3
`define OFS_ENABLE4     3'h0
`define OFS_ENABLE5     3'h1
`define OFS_PRIO0       3'h2
`define OFS_PRIO1       3'h3
`define OFS_PRIO2       3'h4
`define OFS_PRIO3       3'h5
`define OFS_PRESENTED   3'h6

// ----------------------------------------
// Implemented bit masks
// ----------------------------------------
`define MASK_ENABLE4    16'h210e
`define MASK_ENABLE5    16'h3ffe
`define MASK_PRIO0      16'h7777
`define MASK_PRIO1      16'h7770
`define MASK_PRIO2      16'h7777
`define MASK_PRIO3      16'h0077

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_ENABLE      16'h0000
`define RST_PRIO_ALL    16'h4444

// ----------------------------------------
// Enable group 4 bit positions
// ----------------------------------------
`define BIT_CHARGE_TIME 13
`define BIT_LOW_VOLT    8
`define BIT_CHECKSUM    3
`define BIT_SER2_ERR    2
`define BIT_SER1_ERR    1

// ----------------------------------------
// Enable group 5 bit positions
// ----------------------------------------
`define BIT_CAPTURE9    13
`define BIT_COMPARE9    12
`define BIT_SYNC3_EVT   11
`define BIT_SYNC3_FLT   10
`define BIT_SER4_TX     9
`define BIT_SER4_RX     8
`define BIT_SER4_ERR    7
`define BIT_USB         6
`define BIT_TWI3_MST    5
`define BIT_TWI3_SLV    4
`define BIT_SER3_TX     3
`define BIT_SER3_RX     2
`define BIT_SER3_ERR    1

// ----------------------------------------
// Priority field low bit positions
// ----------------------------------------
`define LVL_HI          12
`define LVL_MH          8
`define LVL_ML          4
`define LVL_LO          0
`define LVL_W           3
`define LVL_OFF         3'h0

// ----------------------------------------
// Priority-ranked sources
// ----------------------------------------
`define NUM_SRC         13
`define SRC_W           4

`endif

// File: core/irq_enable_priority_bank.v
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_consts.vh"

module irq_enable_priority_bank (
  // Clock and reset
  input  wire                clk,
  input  wire                reset_n,
  // Register port
  input  wire [`ADDR_W-1:0]  addr,
  input  wire [15:0]         wdata,
  input  wire                wr,
  input  wire                rd,
  output reg  [15:0]         rdata,
  // Enable-gated source flags
  input  wire [15:0]         flags_group4,
  input  wire [15:0]         flags_group5,
  output reg  [15:0]         req_group4,
  output reg  [15:0]         req_group5,
  // Level-ranked source flags and outside enables
  input  wire [`NUM_SRC-1:0] src_flag,
  input  wire [`NUM_SRC-1:0] src_enable,
  output reg  [`NUM_SRC-1:0] src_req,
  // Presented request toward the core
  output reg                 irq_req,
  output reg  [2:0]          irq_level,
  output reg  [`SRC_W-1:0]   irq_source
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg  [15:0] irq_enable_group4;
  reg  [15:0] irq_enable_group5;
  reg  [15:0] irq_priority_group0;
  reg  [15:0] irq_priority_group1;
  reg  [15:0] irq_priority_group2;
  reg  [15:0] irq_priority_group3;

  // ----------------------------------------
  // Named enable fields
  // ----------------------------------------
  wire charge_time_unit_irq_en;
  wire low_voltage_detect_irq_en;
  wire checksum_gen_irq_en;
  wire serial2_error_irq_en;
  wire serial1_error_irq_en;
  wire capture9_irq_en;
  wire compare9_irq_en;
  wire sync_serial3_event_irq_en;
  wire sync_serial3_fault_irq_en;
  wire serial4_tx_irq_en;
  wire serial4_rx_irq_en;
  wire serial4_error_irq_en;
  wire usb_controller_irq_en;
  wire twowire3_master_irq_en;
  wire twowire3_slave_irq_en;
  wire serial3_tx_irq_en;
  wire serial3_rx_irq_en;
  wire serial3_error_irq_en;

  assign charge_time_unit_irq_en   =
    irq_enable_group4[`BIT_CHARGE_TIME];
  assign low_voltage_detect_irq_en = irq_enable_group4[`BIT_LOW_VOLT];
  assign checksum_gen_irq_en       = irq_enable_group4[`BIT_CHECKSUM];
  assign serial2_error_irq_en      = irq_enable_group4[`BIT_SER2_ERR];
  assign serial1_error_irq_en      = irq_enable_group4[`BIT_SER1_ERR];
  assign capture9_irq_en           = irq_enable_group5[`BIT_CAPTURE9];
  assign compare9_irq_en           = irq_enable_group5[`BIT_COMPARE9];
  assign sync_serial3_event_irq_en = irq_enable_group5[`BIT_SYNC3_EVT];
  assign sync_serial3_fault_irq_en = irq_enable_group5[`BIT_SYNC3_FLT];
  assign serial4_tx_irq_en         = irq_enable_group5[`BIT_SER4_TX];
  assign serial4_rx_irq_en         = irq_enable_group5[`BIT_SER4_RX];
  assign serial4_error_irq_en      = irq_enable_group5[`BIT_SER4_ERR];
  assign usb_controller_irq_en     = irq_enable_group5[`BIT_USB];
  assign twowire3_master_irq_en    = irq_enable_group5[`BIT_TWI3_MST];
  assign twowire3_slave_irq_en     = irq_enable_group5[`BIT_TWI3_SLV];
  assign serial3_tx_irq_en         = irq_enable_group5[`BIT_SER3_TX];
  assign serial3_rx_irq_en         = irq_enable_group5[`BIT_SER3_RX];
  assign serial3_error_irq_en      = irq_enable_group5[`BIT_SER3_ERR];

  // ----------------------------------------
  // Enable vectors rebuilt from fields
  // ----------------------------------------
  wire [15:0] next_en4_view;
  wire [15:0] next_en5_view;

  assign next_en4_view = {2'h0, charge_time_unit_irq_en, 4'h0,
                          low_voltage_detect_irq_en, 4'h0,
                          checksum_gen_irq_en, serial2_error_irq_en,
                          serial1_error_irq_en, 1'b0};
  assign next_en5_view = {2'h0, capture9_irq_en, compare9_irq_en,
                          sync_serial3_event_irq_en,
                          sync_serial3_fault_irq_en,
                          serial4_tx_irq_en, serial4_rx_irq_en,
                          serial4_error_irq_en, usb_controller_irq_en,
                          twowire3_master_irq_en, twowire3_slave_irq_en,
                          serial3_tx_irq_en, serial3_rx_irq_en,
                          serial3_error_irq_en, 1'b0};

  // ----------------------------------------
  // Named level fields
  // ----------------------------------------
  wire [2:0] timer_one_level;
  wire [2:0] compare1_level;
  wire [2:0] capture1_level;
  wire [2:0] ext_irq0_level;
  wire [2:0] timer_two_level;
  wire [2:0] compare2_level;
  wire [2:0] capture2_level;
  wire [2:0] serial1_rx_level;
  wire [2:0] sync_serial1_event_level;
  wire [2:0] sync_serial1_fault_level;
  wire [2:0] timer_three_level;
  wire [2:0] adc_done_level;
  wire [2:0] serial1_tx_level;

  assign timer_one_level  = irq_priority_group0[`LVL_HI+:`LVL_W];
  assign compare1_level   = irq_priority_group0[`LVL_MH+:`LVL_W];
  assign capture1_level   = irq_priority_group0[`LVL_ML+:`LVL_W];
  assign ext_irq0_level   = irq_priority_group0[`LVL_LO+:`LVL_W];
  assign timer_two_level  = irq_priority_group1[`LVL_HI+:`LVL_W];
  assign compare2_level   = irq_priority_group1[`LVL_MH+:`LVL_W];
  assign capture2_level   = irq_priority_group1[`LVL_ML+:`LVL_W];
  assign serial1_rx_level = irq_priority_group2[`LVL_HI+:`LVL_W];
  assign sync_serial1_event_level = irq_priority_group2[`LVL_MH+:`LVL_W];
  assign sync_serial1_fault_level = irq_priority_group2[`LVL_ML+:`LVL_W];
  assign timer_three_level = irq_priority_group2[`LVL_LO+:`LVL_W];
  assign adc_done_level    = irq_priority_group3[`LVL_ML+:`LVL_W];
  assign serial1_tx_level  = irq_priority_group3[`LVL_LO+:`LVL_W];

  // ----------------------------------------
  // Source level table, index order
  // ----------------------------------------
  wire [3*`NUM_SRC-1:0] src_level;

  assign src_level = {serial1_tx_level, adc_done_level,
                      serial1_rx_level, sync_serial1_event_level,
                      sync_serial1_fault_level, timer_three_level,
                      timer_two_level, compare2_level, capture2_level,
                      timer_one_level, compare1_level, capture1_level,
                      ext_irq0_level};

  // ----------------------------------------
  // Per-source gates
  // ----------------------------------------
  wire [`NUM_SRC-1:0]   gate_req;
  wire [3*`NUM_SRC-1:0] gate_level;

  genvar g;
  generate
    for (g = 0; g < `NUM_SRC; g = g + 1) begin : src_gate
      irq_source_gate u_gate (
        .flag      (src_flag[g]),
        .enable    (src_enable[g]),
        .level     (src_level[3*g+:3]),
        .req       (gate_req[g]),
        .req_level (gate_level[3*g+:3])
      );
    end
  endgenerate

  // ----------------------------------------
  // Highest level pick, lowest index on a tie
  // ----------------------------------------
  reg [2:0]        next_level;
  reg [`SRC_W-1:0] next_source;
  integer          i;

  always @* begin
    next_level  = `LVL_OFF;
    next_source = {`SRC_W{1'b0}};
    for (i = 0; i < `NUM_SRC; i = i + 1) begin
      if (gate_level[3*i+:3] > next_level) begin
        next_level  = gate_level[3*i+:3];
        next_source = i[`SRC_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Write strobes and masked write values
  // ----------------------------------------
  wire        wr_enable4;
  wire        wr_enable5;
  wire        wr_prio0;
  wire        wr_prio1;
  wire        wr_prio2;
  wire        wr_prio3;
  wire [15:0] next_enable4;
  wire [15:0] next_enable5;
  wire [15:0] next_prio0;
  wire [15:0] next_prio1;
  wire [15:0] next_prio2;
  wire [15:0] next_prio3;

  assign wr_enable4   = wr & (addr == `OFS_ENABLE4);
  assign wr_enable5   = wr & (addr == `OFS_ENABLE5);
  assign wr_prio0     = wr & (addr == `OFS_PRIO0);
  assign wr_prio1     = wr & (addr == `OFS_PRIO1);
  assign wr_prio2     = wr & (addr == `OFS_PRIO2);
  assign wr_prio3     = wr & (addr == `OFS_PRIO3);
  assign next_enable4 = wdata & `MASK_ENABLE4;
  assign next_enable5 = wdata & `MASK_ENABLE5;
  assign next_prio0   = wdata & `MASK_PRIO0;
  assign next_prio1   = wdata & `MASK_PRIO1;
  assign next_prio2   = wdata & `MASK_PRIO2;
  assign next_prio3   = wdata & `MASK_PRIO3;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_enable_group4 <= `RST_ENABLE;
    end else if (wr_enable4) begin
      irq_enable_group4 <= next_enable4;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_enable_group5 <= `RST_ENABLE;
    end else if (wr_enable5) begin
      irq_enable_group5 <= next_enable5;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_priority_group0 <= `RST_PRIO_ALL & `MASK_PRIO0;
    end else if (wr_prio0) begin
      irq_priority_group0 <= next_prio0;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_priority_group1 <= `RST_PRIO_ALL & `MASK_PRIO1;
    end else if (wr_prio1) begin
      irq_priority_group1 <= next_prio1;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_priority_group2 <= `RST_PRIO_ALL & `MASK_PRIO2;
    end else if (wr_prio2) begin
      irq_priority_group2 <= next_prio2;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_priority_group3 <= `RST_PRIO_ALL & `MASK_PRIO3;
    end else if (wr_prio3) begin
      irq_priority_group3 <= next_prio3;
    end
  end

  // ----------------------------------------
  // Presented request as a readable word
  // ----------------------------------------
  wire [15:0] presented_word;

  assign presented_word = {8'h00, irq_req, irq_level, irq_source};

  // ----------------------------------------
  // Register reads, data one cycle later
  // ----------------------------------------
  reg [15:0] next_rdata;

  always @* begin
    case (addr)
      `OFS_ENABLE4:   next_rdata = next_en4_view;
      `OFS_ENABLE5:   next_rdata = next_en5_view;
      `OFS_PRIO0:     next_rdata = irq_priority_group0;
      `OFS_PRIO1:     next_rdata = irq_priority_group1;
      `OFS_PRIO2:     next_rdata = irq_priority_group2;
      `OFS_PRIO3:     next_rdata = irq_priority_group3;
      `OFS_PRESENTED: next_rdata = presented_word;
      default:        next_rdata = 16'h0000;
    endcase
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata <= 16'h0000;
    end else if (rd) begin
      rdata <= next_rdata;
    end else begin
      rdata <= 16'h0000;
    end
  end

  // ----------------------------------------
  // Enable-gated requests
  // ----------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_group4 <= 16'h0000;
      req_group5 <= 16'h0000;
    end else begin
      req_group4 <= flags_group4 & next_en4_view;
      req_group5 <= flags_group5 & next_en5_view;
    end
  end

  // ----------------------------------------
  // Level-ranked requests and presented source
  // ----------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      src_req    <= {`NUM_SRC{1'b0}};
      irq_req    <= 1'b0;
      irq_level  <= `LVL_OFF;
      irq_source <= {`SRC_W{1'b0}};
    end else begin
      src_req    <= gate_req;
      irq_req    <= |gate_req;
      irq_level  <= next_level;
      irq_source <= next_source;
    end
  end

endmodule

`default_nettype wire

// File: core/irq_source_gate.v
`timescale 1ns/1ps
`default_nettype none

module irq_source_gate (
  // Source state
  input  wire       flag,
  input  wire       enable,
  input  wire [2:0] level,
  // Gated request
  output wire       req,
  output wire [2:0] req_level
);

  // ----------------------------------------
  // Gate
  // ----------------------------------------
  assign req       = flag & enable & (|level);
  assign req_level = req ? level : 3'h0;

endmodule

`default_nettype wire

// File: verification/irq_bank_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_consts.vh"
module irq_bank_chk (
  // Clock and reset
  input wire logic                clk,
  input wire logic                reset_n,
  // Register port
  input wire logic [`ADDR_W-1:0]  addr,
  input wire logic [15:0]         wdata,
  input wire logic                wr,
  input wire logic                rd,
  input wire logic [15:0]         rdata,
  // Sources
  input wire logic [15:0]         flags_group4,
  input wire logic [15:0]         flags_group5,
  input wire logic [15:0]         req_group4,
  input wire logic [15:0]         req_group5,
  input wire logic [`NUM_SRC-1:0] src_flag,
  input wire logic [`NUM_SRC-1:0] src_enable,
  input wire logic [`NUM_SRC-1:0] src_req,
  // Presented request
  input wire logic                irq_req,
  input wire logic [2:0]          irq_level,
  input wire logic [`SRC_W-1:0]   irq_source
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_after_reset: assert property (!$past(reset_n) |->
    src_req == 0 && !irq_req && req_group4 == 0) else $error("not idle");
  a_unmapped_zero: assert property ($past(rd) && $past(addr) == 3'h7
    |-> rdata == 16'h0) else $error("unmapped read");
  a_enable4_unused: assert property ($past(rd) &&
    $past(addr) == `OFS_ENABLE4 |-> (rdata & 16'hdef1) == 16'h0)
    else $error("enable4 unused bits");
  a_prio1_unused: assert property ($past(rd) &&
    $past(addr) == `OFS_PRIO1 |-> (rdata & 16'h888f) == 16'h0)
    else $error("prio1 unused bits");
  a_prio3_unused: assert property ($past(rd) &&
    $past(addr) == `OFS_PRIO3 |-> (rdata & 16'hff88) == 16'h0)
    else $error("prio3 unused bits");
  a_req4_bits: assert property ((req_group4 & 16'hdef1) == 16'h0)
    else $error("req4 unused bit");
  a_req5_bits: assert property ((req_group5 & 16'hc001) == 16'h0)
    else $error("req5 unused bit");
  a_req_flag: assert property (((req_group4 & ~$past(flags_group4)) |
    (req_group5 & ~$past(flags_group5))) == 16'h0) else $error("no flag");
  a_enable_clear: assert property (wr && addr == `OFS_ENABLE4 &&
    wdata == 16'h0 |-> ##2 req_group4 == 16'h0) else $error("not blocked");
  a_src_gate: assert property ((src_req &
    ~($past(src_flag) & $past(src_enable))) == 0) else $error("src gate");
  a_irq_any: assert property (irq_req == (|src_req))
    else $error("irq_req mismatch");
  a_level_live: assert property (irq_req |-> irq_level != 3'h0 &&
    src_req[irq_source]) else $error("bad presented source");
endmodule
`default_nettype wire

// File: verification/irq_enable_priority_bank_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "irq_bank_consts.vh"
module irq_enable_priority_bank_tb_top;
  logic              clk, reset_n, wr, rd, irq_req;
  logic [2:0]        addr, irq_level;
  logic [3:0]        irq_source;
  logic [15:0]       wdata, rdata, want4, want5, req_group4, req_group5;
  logic [15:0]       flags_group4, flags_group5;
  logic [12:0]       want_flag, want_en, src_flag, src_enable, src_req;
  logic [15:0]       rst[8] = '{16'h0000, 16'h0000, 16'h4444, 16'h4440,
                                16'h4444, 16'h0044, 16'h0000, 16'h0000};
  logic [15:0]       msk[8] = '{16'h210e, 16'h3ffe, 16'h7777, 16'h7770,
                                16'h7777, 16'h0077, 16'h0000, 16'h0000};
  int                reg_of[13] = '{2, 2, 2, 2, 3, 3, 3, 4, 4, 4, 4, 5, 5};
  int                sh_of[13] = '{0, 4, 8, 12, 4, 8, 12, 0, 4, 8, 12, 4, 0};
  int                n_fail, comparisons;

  irq_enable_priority_bank u_irq_enable_priority_bank (.clk(clk),
    .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .flags_group4(flags_group4), .flags_group5(flags_group5),
    .req_group4(req_group4), .req_group5(req_group5), .src_flag(src_flag),
    .src_enable(src_enable), .src_req(src_req), .irq_req(irq_req),
    .irq_level(irq_level), .irq_source(irq_source));
  irq_source_model u_irq_source_model (.clk(clk), .reset_n(reset_n),
    .want4(want4), .want5(want5), .want_flag(want_flag), .want_en(want_en),
    .flags_group4(flags_group4), .flags_group5(flags_group5),
    .src_flag(src_flag), .src_enable(src_enable));

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 cmp(rdata, e);
  endtask
  task automatic drive(input logic [15:0] w4, w5, input logic [12:0] f, e);
    @(posedge clk);
    want4 <= w4;
    want5 <= w5;
    want_flag <= f;
    want_en <= e;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic close_out;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #1000000;
    n_fail++;
    close_out();
  end
  initial begin
    {reset_n, wr, rd, addr, wdata, want4, want5, want_flag, want_en} <= '0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    for (int i = 0; i < 8; i++) rd_reg(i[2:0], rst[i]);
    $display("reset values done");
    for (int i = 0; i < 8; i++) wr_reg(i[2:0], 16'hffff);
    for (int i = 0; i < 8; i++) rd_reg(i[2:0], msk[i]);
    $display("masks done");
    drive(16'hffff, 16'hffff, 13'h0000, 13'h0000);
    cmp(req_group4, 16'h210e);
    cmp(req_group5, 16'h3ffe);
    wr_reg(`OFS_ENABLE5, 16'h00aa);
    drive(16'hffff, 16'hffff, 13'h0000, 13'h0000);
    cmp(req_group5, 16'h00aa);
    wr_reg(`OFS_ENABLE4, 16'h0000);
    drive(16'hffff, 16'hffff, 13'h0000, 13'h0000);
    cmp(req_group4, 16'h0000);
    $display("gating done");
    for (int i = 0; i < 13; i++) begin
      for (int lv = 0; lv < 8; lv++) begin
        wr_reg(reg_of[i][2:0], 16'(lv << sh_of[i]));
        drive(16'h0000, 16'h0000, 13'(1 << i), 13'h1fff);
        cmp({8'h0, irq_req, irq_level, irq_source},
            lv == 0 ? 16'h0 : {8'h0, 1'b1, 3'(lv), 4'(i)});
      end
    end
    rd_reg(`OFS_PRIO3, 16'h0007);
    drive(16'h0000, 16'h0000, 13'h1000, 13'h0000);
    cmp({8'h0, irq_req, irq_level, irq_source}, 16'h0);
    $display("levels done");
    for (int k = 3; k < 6; k++) wr_reg(k[2:0], 16'h0000);
    wr_reg(`OFS_PRIO0, 16'h1234);
    drive(16'h0000, 16'h0000, 13'h1fff, 13'h1fff);
    cmp({3'h0, src_req}, 16'h000f);
    cmp({8'h0, irq_req, irq_level, irq_source}, 16'h00c0);
    wr_reg(`OFS_PRIO0, 16'h0550);
    rd_reg(`OFS_PRESENTED, 16'h00d1);
    $display("ranking done");
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    #1 cmp({8'h0, irq_req, irq_level, irq_source}, 16'h0);
    @(posedge clk);
    reset_n <= 1'b1;
    drive(16'h0000, 16'h0000, 13'h1fff, 13'h1fff);
    cmp({8'h0, irq_req, irq_level, irq_source}, 16'h00c0);
    rd_reg(`OFS_PRIO0, 16'h4444);
    $display("second reset done");
    close_out();
  end
endmodule
bind irq_enable_priority_bank irq_bank_chk u_irq_bank_chk (.clk(clk),
  .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
  .rdata(rdata), .flags_group4(flags_group4), .flags_group5(flags_group5),
  .req_group4(req_group4), .req_group5(req_group5), .src_flag(src_flag),
  .src_enable(src_enable), .src_req(src_req), .irq_req(irq_req),
  .irq_level(irq_level), .irq_source(irq_source));
`default_nettype wire

// File: verification/irq_source_model.sv
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // Wanted source state
  input  wire logic [15:0] want4,
  input  wire logic [15:0] want5,
  input  wire logic [12:0] want_flag,
  input  wire logic [12:0] want_en,
  // Flags toward the bank
  output var  logic [15:0] flags_group4,
  output var  logic [15:0] flags_group5,
  output var  logic [12:0] src_flag,
  output var  logic [12:0] src_enable
);
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      flags_group4 <= 16'h0;
      flags_group5 <= 16'h0;
      src_flag     <= 13'h0;
      src_enable   <= 13'h0;
    end else begin
      flags_group4 <= want4;
      flags_group5 <= want5;
      src_flag     <= want_flag;
      src_enable   <= want_en;
    end
  end
endmodule
`default_nettype wire
